/* File: logic/current_scaler.sv */
`timescale 1ns/1ps
`default_nettype none
module current_scaler (
	// settings
	input  wire logic [15:0] full_scale,
	input  wire logic [7:0]  ratio_pct,
	input  wire logic [15:0] reduce_pct,
	// results
	output logic      [15:0] run_current,
	output logic      [15:0] idle_current
);
	import stepper_pkg::*;
	logic [31:0] run_w;
	logic [31:0] idle_w;

	// divide late to keep rounding loss to one step
	always_comb begin
		run_w = (32'(full_scale) * 32'(ratio_pct)) / 32'(PCT_DIV);
		idle_w = (32'(full_scale) * 32'(ratio_pct) * 32'(reduce_pct))
			/ (32'(PCT_DIV) * 32'(PCT_DIV));
		run_current = run_w[15:0];
		idle_current = idle_w[15:0];
	end
endmodule
`default_nettype wire

/* File: logic/lag_if.sv */
`timescale 1ns/1ps
`default_nettype none
// position data from the controller to the window checker
interface lag_if;
	logic [31:0] actual_pos;
	logic [31:0] cmd_pos;
	logic [31:0] sync_win;
	logic [15:0] encoder_counts_per_turn;
	logic [7:0]  win_code;
	logic        sync_en;
	logic        trip;
	logic        in_sync;
	modport mon (input actual_pos, cmd_pos, sync_win, encoder_counts_per_turn, win_code, sync_en, output trip, in_sync);
	modport ctl (output actual_pos, cmd_pos, sync_win, encoder_counts_per_turn, win_code, sync_en, input trip, in_sync);
endinterface
`default_nettype wire

/* File: logic/lag_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module lag_monitor (
	lag_if.mon p
);
	import stepper_pkg::*;
	logic signed [32:0] diff;
	logic [32:0] mag;
	logic [47:0] lhs;
	logic [47:0] rhs;
	logic [2:0]  sel;

	// compare mag*400 against cpr*k so no divider is needed
	always_comb begin
		diff = $signed({p.actual_pos[31], p.actual_pos}) - $signed({p.cmd_pos[31], p.cmd_pos});
		mag = diff[32] ? 33'(-diff) : 33'(diff);
		sel = (p.win_code > WIN_MAX) ? WIN_MAX[2:0] : p.win_code[2:0];
		lhs = 48'(mag) * 48'(WIN_STEPS_PER_TURN);
		rhs = 48'(p.encoder_counts_per_turn) * 48'(WIN_MULT[sel]);
		if (p.sync_en) begin
			p.trip = mag > {1'b0, p.sync_win};
		end else begin
			p.trip = lhs > rhs;
		end
		p.in_sync = (mag == 33'h0);
	end
endmodule
`default_nettype wire

/* File: logic/stepper_current_and_following_error.sv */
`timescale 1ns/1ps
`default_nettype none
module stepper_current_and_following_error #(
	parameter int unsigned REDUCE_CYCLES = stepper_pkg::REDUCE_CYCLES_DFLT
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// register port
	input  wire stepper_pkg::addr_t reg_addr,
	input  wire logic               reg_wr,
	input  wire stepper_pkg::word_t reg_wdata,
	input  wire logic               reg_rd,
	output logic      [15:0]        reg_rdata_ff,
	// drive state and motion
	input  wire logic               op_enabled,
	input  wire logic               current_on,
	input  wire logic               motor_running,
	input  wire logic               run_start,
	input  wire logic               run_has_ramp,
	input  wire logic               steps_done,
	input  wire stepper_pkg::word_t control_word,
	input  wire stepper_pkg::word_t base_status,
	input  wire logic [15:0]        full_scale_current,
	// positions
	input  wire logic [31:0]        enc_pos,
	input  wire logic [31:0]        cmd_pos,
	input  wire logic [31:0]        step_count,
	// outputs
	output logic [15:0]             phase_current_ff,
	output logic                    equalize_on_ff,
	output logic                    decel_stop_ff,
	output logic                    halt_now_ff,
	output logic                    coast_off_ff,
	output logic                    ignore_target_ff,
	output logic [31:0]             actual_pos_ff,
	output logic [15:0]             status_word_ff
);
	import stepper_pkg::*;

	logic [7:0]  ratio_ff;
	logic [15:0] steprev_ff;
	logic [7:0]  eq_ff;
	logic [7:0]  reduce_ff;
	logic [7:0]  win_ff;
	logic [7:0]  react_ff;
	logic [7:0]  clr_cmd_ff;
	logic        sync_en_ff;
	logic [31:0] sync_win_ff;
	logic [15:0] red_pct_ff;
	logic [15:0] cpr_ff;
	logic [31:0] offset_ff;
	logic        lag_ff;
	logic        treach_ff;
	logic        run_q_ff;
	logic        cur_q_ff;
	logic        reduced_ff;
	logic [23:0] idle_cnt_ff;
	lag_state_t  state_ff;
	lag_state_t  nxt_state;
	logic [15:0] run_cur;
	logic [15:0] idle_cur;
	logic        wr_hit;
	logic        clr_go;
	logic        trip_ev;
	logic        cur_drop;
	logic        run_end;
	logic        no_enc;

	lag_if lif ();

	assign no_enc   = (react_ff == RC_NOENC);
	assign cur_drop = cur_q_ff & ~current_on;
	assign run_end  = run_q_ff & ~motor_running;
	assign wr_hit   = reg_wr;
	// reset command only in operation enabled with current, never without encoder
	assign clr_go = wr_hit & (reg_addr == ADDR_CLR)
		& ((reg_wdata[7:0] == CLR_OFFSET) | (reg_wdata[7:0] == CLR_LOAD))
		& op_enabled & current_on & ~no_enc;
	// sync-loss only counts while the motor is powered and the encoder used
	assign trip_ev = lif.trip & ~no_enc & current_on & (state_ff == ST_IDLE);

	assign lif.actual_pos = enc_pos - offset_ff; // same-cycle positions; the registered copy lags a count while moving
	assign lif.cmd_pos    = cmd_pos;
	assign lif.sync_win   = sync_win_ff;
	assign lif.encoder_counts_per_turn        = cpr_ff;
	assign lif.win_code   = win_ff;
	assign lif.sync_en    = sync_en_ff;

	lag_monitor u_mon (
		.p (lif.mon)
	);

	current_scaler u_scl (
		.full_scale   (full_scale_current),
		.ratio_pct    (ratio_ff),
		.reduce_pct   (red_pct_ff),
		.run_current  (run_cur),
		.idle_current (idle_cur)
	);

	// settings registers; out-of-range values are dropped, old value kept; sync enable takes bit 0 of any value
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ratio_ff    <= RATIO_RST;
			steprev_ff  <= STEPREV_RST;
			eq_ff       <= 8'h00;
			reduce_ff   <= REDUCE_RST;
			win_ff      <= WIN_RST;
			react_ff    <= RC_STOP;
			sync_en_ff  <= 1'b0;
			sync_win_ff <= SYNC_W_RST;
			red_pct_ff  <= RED_PCT_RST;
			cpr_ff      <= CPR_RST;
		end else if (wr_hit) begin
			case (reg_addr)
				ADDR_RATIO: begin
					if (reg_wdata <= 16'(RATIO_MAX)) ratio_ff <= reg_wdata[7:0];
				end
				ADDR_STEPREV: begin
					if (reg_wdata == STEPREV_RST) steprev_ff <= reg_wdata;
				end
				ADDR_EQ: begin
					if (!motor_running && reg_wdata <= 16'h0001) eq_ff <= reg_wdata[7:0];
				end
				ADDR_REDUCE: begin
					if (reg_wdata <= 16'h0001) reduce_ff <= reg_wdata[7:0];
				end
				ADDR_WIN: begin
					if (reg_wdata <= 16'(WIN_MAX)) win_ff <= reg_wdata[7:0];
				end
				ADDR_REACT: begin
					if (reg_wdata == 16'(RC_NOENC)) begin
						if (!op_enabled) react_ff <= RC_NOENC;
					end else if (reg_wdata <= 16'(RC_COAST)) begin
						react_ff <= reg_wdata[7:0];
					end
				end
				ADDR_SYNC_EN: sync_en_ff <= reg_wdata[0];
				ADDR_SYNC_WL: sync_win_ff[15:0] <= reg_wdata;
				ADDR_SYNC_WH: sync_win_ff[31:16] <= reg_wdata;
				ADDR_RED_PCT: begin
					if (reg_wdata <= RED_PCT_MAX) red_pct_ff <= reg_wdata;
				end
				ADDR_CPR: begin
					if (reg_wdata >= CPR_MIN && reg_wdata <= CPR_MAX) cpr_ff <= reg_wdata;
				end
				default: ;
			endcase
		end
	end

	// reset register keeps what the host wrote; host must put 0 back itself
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			clr_cmd_ff <= 8'h00;
		end else if (wr_hit && reg_addr == ADDR_CLR && reg_wdata <= 16'(CLR_LOAD)) begin
			clr_cmd_ff <= reg_wdata[7:0];
		end
	end

	// encoder offset; reset command realigns actual to command or to step count
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			offset_ff <= 32'h0000_0000;
		end else if (clr_go) begin
			if (reg_wdata[7:0] == CLR_OFFSET && !sync_en_ff) begin
				offset_ff <= enc_pos - cmd_pos;
			end else if (reg_wdata[7:0] == CLR_LOAD && cpr_ff == CPR_REQ_LD) begin
				offset_ff <= enc_pos - step_count;
			end
		end
	end

	// without encoder the reported position is the command itself
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			actual_pos_ff <= 32'h0000_0000;
		end else if (no_enc) begin
			actual_pos_ff <= cmd_pos;
		end else begin
			actual_pos_ff <= enc_pos - offset_ff;
		end
	end

	// edge history for run end and current removal
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			run_q_ff <= 1'b0;
			cur_q_ff <= 1'b0;
		end else begin
			run_q_ff <= motor_running;
			cur_q_ff <= current_on;
		end
	end

	// following-error flag; a new alarm wins over any clear in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lag_ff <= 1'b0;
		end else if (no_enc) begin
			lag_ff <= 1'b0;
		end else if (trip_ev) begin
			lag_ff <= 1'b1;
		end else if (clr_go && (reg_wdata[7:0] == CLR_OFFSET || cpr_ff == CPR_REQ_LD)) begin
			lag_ff <= 1'b0;
		end else if (cur_drop || state_ff == ST_FAULT) begin
			lag_ff <= 1'b0;
		end else if (react_ff != RC_KEEP && run_start && state_ff == ST_IDLE) begin
			lag_ff <= 1'b0;
		end else if (react_ff == RC_KEEP && sync_en_ff && lif.in_sync) begin
			lag_ff <= 1'b0;
		end
	end

	// reaction sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (trip_ev && react_ff == RC_STOP) nxt_state = ST_DECEL;
				else if (trip_ev && react_ff == RC_COAST) nxt_state = ST_COAST;
			end
			ST_DECEL: begin
				if (!motor_running) nxt_state = ST_IDLE;
			end
			ST_COAST: begin
				if (!motor_running) nxt_state = ST_FAULT;
			end
			ST_FAULT: begin
				if (control_word == CW_FAULT_RST) nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) state_ff <= ST_IDLE;
		else state_ff <= nxt_state;
	end

	// stop requests: ramp run decelerates, ramp-less run halts at once
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			decel_stop_ff    <= 1'b0;
			halt_now_ff      <= 1'b0;
			coast_off_ff     <= 1'b0;
			ignore_target_ff <= 1'b0;
		end else begin
			decel_stop_ff    <= (nxt_state == ST_DECEL) & run_has_ramp;
			halt_now_ff      <= (nxt_state == ST_DECEL) & ~run_has_ramp;
			coast_off_ff     <= (nxt_state == ST_COAST) | (nxt_state == ST_FAULT);
			ignore_target_ff <= (nxt_state == ST_COAST);
		end
	end

	// target reached: on stop after an error, else when all steps are issued
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			treach_ff <= 1'b0;
		end else if (state_ff == ST_DECEL && !motor_running) begin
			treach_ff <= 1'b1;
		end else if (steps_done && state_ff == ST_IDLE) begin
			treach_ff <= 1'b1;
		end else if (run_start && state_ff == ST_IDLE) begin
			treach_ff <= 1'b0;
		end
	end

	// standstill timer; long count is a parameter so simulation can shorten it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			idle_cnt_ff <= 24'h00_0000;
			reduced_ff  <= 1'b0;
		end else if (motor_running || reduce_ff != REDUCE_RST) begin
			idle_cnt_ff <= 24'h00_0000;
			reduced_ff  <= 1'b0;
		end else if (run_end) begin
			idle_cnt_ff <= 24'h00_0001;
		end else if (idle_cnt_ff != 24'h00_0000 && !reduced_ff) begin
			if (idle_cnt_ff >= 24'(REDUCE_CYCLES)) begin
				reduced_ff <= 1'b1;
			end else begin
				idle_cnt_ff <= idle_cnt_ff + 24'h00_0001;
			end
		end
	end

	// winding current; forced to zero while coasting or in fault
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			phase_current_ff <= 16'h0000;
		end else if (coast_off_ff) begin
			phase_current_ff <= 16'h0000;
		end else if (reduced_ff) begin
			phase_current_ff <= idle_cur;
		end else begin
			phase_current_ff <= run_cur;
		end
	end

	// resynchronisation overrides the equalization setting
	always_ff @(posedge clk) begin
		if (!rst_n) equalize_on_ff <= 1'b0;
		else equalize_on_ff <= eq_ff[0] & ~sync_en_ff;
	end

	// status word: fixed codes in coast and fault, else drive bits plus ours
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			status_word_ff <= 16'h0000;
		end else if (state_ff == ST_COAST) begin
			status_word_ff <= SW_COAST;
		end else if (state_ff == ST_FAULT) begin
			status_word_ff <= SW_FAULT;
		end else begin
			status_word_ff <= base_status;
			status_word_ff[BIT_TREACH] <= treach_ff;
			status_word_ff[BIT_LAG] <= lag_ff & ~no_enc;
		end
	end

	// read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata_ff <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				ADDR_RATIO:   reg_rdata_ff <= {8'h00, ratio_ff};
				ADDR_STEPREV: reg_rdata_ff <= steprev_ff;
				ADDR_EQ:      reg_rdata_ff <= {8'h00, eq_ff};
				ADDR_REDUCE:  reg_rdata_ff <= {8'h00, reduce_ff};
				ADDR_WIN:     reg_rdata_ff <= {8'h00, win_ff};
				ADDR_REACT:   reg_rdata_ff <= {8'h00, react_ff};
				ADDR_CLR:     reg_rdata_ff <= {8'h00, clr_cmd_ff};
				ADDR_SYNC_EN: reg_rdata_ff <= {15'h0000, sync_en_ff};
				ADDR_SYNC_WL: reg_rdata_ff <= sync_win_ff[15:0];
				ADDR_SYNC_WH: reg_rdata_ff <= sync_win_ff[31:16];
				ADDR_RED_PCT: reg_rdata_ff <= red_pct_ff;
				ADDR_FULLSCL: reg_rdata_ff <= full_scale_current;
				ADDR_CPR:     reg_rdata_ff <= cpr_ff;
				default:      reg_rdata_ff <= 16'h0000;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: logic/stepper_pkg.sv */
// Notes on behaviour
// - peak current is full scale times ratio over 100; ratio 0..120, default 70.
// - equalization 0 off, 1 on; new value taken only while the motor is stopped.
// - automatic resynchronisation forces equalization off.
// - reduction set to 1 lowers current about 80 ms after a run ends at standstill.
// - reduced current is full scale times ratio over 100 times reduction over 100.
// - window codes 0..5 mean 0.9 to 9.0 degrees; exceeding raises sync-loss.
// - reaction 17 means no encoder: no sync-loss, window ignored.
// - with resynchronisation on, the 32-bit window value replaces the window code.
// - any following-error alarm sets status bit 13 in every mode.
// - reaction 0 stops the motor, bit 10 on stop, bit 13 held to next run.
// - reaction 1 keeps running; bit 10 set once all commanded steps are issued.
// - reaction 1 holds bit 13 until reset command 1 or 2 or current removal.
// - reaction 1 with resynchronisation clears bit 13 when positions match again.
// - reaction 2 coasts with current off, status 0x201F, new targets ignored.
// - reaction 2 enters fault 0x1218 when the motor stops; remote bit 9 set.
// - reaction 0x11: no alarm, actual equals command, bit 13 zero, written below enabled.
// - reset 1 clears bit 13; without resynchronisation it also sets the encoder offset so actual equals command.
// - reaction 0 or 2 clears bit 13 on current off or a new move.
// - reset commands ignored unless operation enabled with current, and always ignored with reaction 0x11.
// - reset 2 loads the step counter into actual position, only when counts are 400.
package stepper_pkg;
	typedef logic [15:0] addr_t;
	typedef logic [15:0] word_t;
	localparam addr_t ADDR_RATIO    = 16'h0438;
	localparam addr_t ADDR_STEPREV  = 16'h0439;
	localparam addr_t ADDR_EQ       = 16'h043A;
	localparam addr_t ADDR_REDUCE   = 16'h043B;
	localparam addr_t ADDR_WIN      = 16'h043C;
	localparam addr_t ADDR_REACT    = 16'h043D;
	localparam addr_t ADDR_CLR      = 16'h043E;
	localparam addr_t ADDR_SYNC_EN  = 16'h0454;
	localparam addr_t ADDR_SYNC_WL  = 16'h0456;
	localparam addr_t ADDR_SYNC_WH  = 16'h0457;
	localparam addr_t ADDR_RED_PCT  = 16'h0458;
	localparam addr_t ADDR_FULLSCL  = 16'h045D;
	localparam addr_t ADDR_CPR      = 16'h0461;
	localparam logic [7:0]  RATIO_RST   = 8'h46;
	localparam logic [7:0]  RATIO_MAX   = 8'h78;
	localparam logic [15:0] STEPREV_RST = 16'h3200;
	localparam logic [7:0]  REDUCE_RST  = 8'h01;
	localparam logic [7:0]  WIN_RST     = 8'h03;
	localparam logic [7:0]  WIN_MAX     = 8'h05;
	localparam logic [31:0] SYNC_W_RST  = 32'h0000_7D00;
	localparam logic [15:0] RED_PCT_RST = 16'h0032;
	localparam logic [15:0] RED_PCT_MAX = 16'h0064;
	localparam logic [15:0] CPR_RST     = 16'h0190;
	localparam logic [15:0] CPR_REQ_LD  = 16'h0190;
	localparam logic [15:0] CPR_MIN     = 16'h0190;
	localparam logic [15:0] CPR_MAX     = 16'h0FA0;
	localparam logic [7:0] RC_STOP  = 8'h00;
	localparam logic [7:0] RC_KEEP  = 8'h01;
	localparam logic [7:0] RC_COAST = 8'h02;
	localparam logic [7:0] RC_NOENC = 8'h11;
	localparam logic [7:0] CLR_OFFSET = 8'h01;
	localparam logic [7:0] CLR_LOAD   = 8'h02;
	localparam int BIT_REMOTE = 9;
	localparam int BIT_TREACH = 10;
	localparam int BIT_B12    = 12;
	localparam int BIT_LAG    = 13;
	localparam word_t SW_COAST      = 16'h201F;
	localparam word_t SW_FAULT      = 16'h1218;
	localparam word_t CW_FAULT_RST  = 16'h0080;
	localparam logic [15:0] PCT_DIV = 16'h0064;
	// window step is 0.9 degree, i.e. counts per turn over 400
	localparam logic [15:0] WIN_STEPS_PER_TURN = 16'h0190;
	localparam logic [3:0] WIN_MULT [0:5] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hA};
	localparam int REDUCE_DELAY_MS = 80;
	localparam int CLK_HZ          = 20_000_000;
	localparam int REDUCE_CYCLES_DFLT = REDUCE_DELAY_MS * (CLK_HZ / 1000);
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_DECEL = 2'b01,
		ST_COAST = 2'b11,
		ST_FAULT = 2'b10
	} lag_state_t;
endpackage

/* File: verif/lag_error_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module lag_error_chk #(
	parameter int unsigned REDUCE_CYCLES = stepper_pkg::REDUCE_CYCLES_DFLT
) (
	// clock and reset
	input wire logic               clk,
	input wire logic               rst_n,
	// register port
	input wire stepper_pkg::addr_t reg_addr,
	input wire logic               reg_wr,
	input wire stepper_pkg::word_t reg_wdata,
	// drive state
	input wire logic               op_enabled,
	input wire logic               current_on,
	input wire logic               run_has_ramp,
	input wire stepper_pkg::word_t control_word,
	input wire logic [31:0]        enc_pos,
	input wire logic [31:0]        cmd_pos,
	// outputs watched
	input wire logic               decel_stop_ff,
	input wire logic               halt_now_ff,
	input wire logic               coast_off_ff,
	input wire logic               ignore_target_ff,
	input wire logic [31:0]        actual_pos_ff,
	input wire logic [15:0]        status_word_ff
);
	import stepper_pkg::*;
	logic [7:0] react_ff;
	// shadow of the accepted reaction code; no-encoder is refused once enabled
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			react_ff <= RC_STOP;
		end else if (reg_wr && reg_addr == ADDR_REACT && (reg_wdata inside {16'h0000, 16'h0001, 16'h0002}
			|| (reg_wdata == 16'h0011 && !op_enabled))) begin
			react_ff <= reg_wdata[7:0];
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_clr(v);
		reg_wr && reg_addr == ADDR_CLR && reg_wdata == v;
	endsequence
	sequence s_coast_end;
		$fell(ignore_target_ff) && coast_off_ff;
	endsequence
	a_ramp_stop: assert property ($rose(decel_stop_ff) |-> $past(run_has_ramp) ##1 status_word_ff[BIT_LAG])
		else $error("ramped stop without ramp or without lag flag");
	a_halt_now: assert property ($rose(halt_now_ff) |-> !$past(run_has_ramp) ##1 status_word_ff[BIT_LAG])
		else $error("immediate stop on a ramped run or without lag flag");
	a_coast_word: assert property ($rose(ignore_target_ff) |-> coast_off_ff ##1 status_word_ff == SW_COAST)
		else $error("coast status word wrong");
	a_fault_word: assert property (s_coast_end |-> ##[0:2] status_word_ff == SW_FAULT)
		else $error("fault status word missing after coast");
	a_fault_exit: assert property (status_word_ff == SW_FAULT && control_word == CW_FAULT_RST
		|-> ##[1:3] !coast_off_ff)
		else $error("fault reset word did not leave fault");
	a_noenc_actual: assert property ((react_ff == RC_NOENC && $stable(cmd_pos)) [*3] |-> actual_pos_ff == cmd_pos)
		else $error("actual position differs from command without encoder");
	a_clr_ignored: assert property (s_clr(16'h0001) ##0 !op_enabled && react_ff == RC_KEEP
		&& status_word_ff[BIT_LAG] ##1 current_on [*2] |-> status_word_ff[BIT_LAG])
		else $error("clear taken outside operation enabled");
	a_clr_works: assert property (s_clr(16'h0001) ##0 op_enabled && current_on && react_ff != RC_NOENC
		&& !coast_off_ff && enc_pos == cmd_pos |-> ##2 !status_word_ff[BIT_LAG])
		else $error("clear command left the lag flag set");
	a_curr_drop: assert property ($fell(current_on) && !coast_off_ff |-> ##2 !status_word_ff[BIT_LAG])
		else $error("lag flag survived current removal");
endmodule
`default_nettype wire

/* File: verif/motion_model.sv */
`timescale 1ns/1ps
`default_nettype none
module motion_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// requests from bench and drive
	input  wire logic        go,
	input  wire logic        halt,
	input  wire logic [31:0] lag,
	// motion seen by the drive
	output logic             motor_running,
	output logic             run_start,
	output logic             steps_done,
	output logic      [31:0] cmd_pos,
	output logic      [31:0] step_count,
	output logic      [31:0] enc_pos
);
	logic [7:0] left_ff;
	// encoder runs ahead of the command by the slip the bench injects
	assign enc_pos = cmd_pos + lag;
	// fixed-length move; a stop request cuts it to a short ramp, not a dead stop
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			motor_running <= 1'b0;
			run_start     <= 1'b0;
			steps_done    <= 1'b0;
			cmd_pos       <= 32'h0;
			step_count    <= 32'h0000_0100; // differs from command so a load is visible
			left_ff       <= 8'h0;
		end else begin
			run_start  <= go && !motor_running;
			steps_done <= motor_running && left_ff == 8'h1 && !halt;
			if (go && !motor_running) begin
				motor_running <= 1'b1;
				left_ff       <= 8'h28;
			end else if (motor_running) begin
				cmd_pos       <= cmd_pos + 32'h1;
				step_count    <= step_count + 32'h1;
				left_ff       <= (halt && left_ff > 8'h3) ? 8'h3 : left_ff - 8'h1;
				motor_running <= left_ff != 8'h1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: verif/stepper_current_and_following_error_test.sv */
`timescale 1ns/1ps
`default_nettype none
module stepper_current_and_following_error_test;
	import stepper_pkg::*;
	typedef struct {int unsigned sel; logic [31:0] val;} note_t;
	logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, go = 0, look = 0;
	logic        op_enabled = 1, current_on = 1, run_has_ramp = 1, halt;
	addr_t       reg_addr = 16'h0;
	word_t       reg_wdata = 16'h0, control_word = 16'h0;
	logic [15:0] reg_rdata_ff, phase_current_ff, status_word_ff;
	logic        equalize_on_ff, decel_stop_ff, halt_now_ff, coast_off_ff, ignore_target_ff;
	logic        motor_running, run_start, steps_done;
	logic [31:0] lag = 32'h0, cmd_pos, step_count, enc_pos, actual_pos_ff, seed = 32'hF73B, r;
	logic [31:0] rst_v [7] = '{32'h46, 32'h3200, 32'h0, 32'h1, 32'h3, 32'h0, 32'h0};
	int          err_total = 0, n_tests = 0;
	note_t       q[$];
	// short reduction delay keeps the standstill case to a few dozen cycles
	stepper_current_and_following_error #(.REDUCE_CYCLES(20)) dut_u (.clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata,
		.reg_rd, .reg_rdata_ff, .op_enabled, .current_on, .motor_running, .run_start, .run_has_ramp, .steps_done,
		.control_word, .base_status(16'h1237), .full_scale_current(16'h03E8), .enc_pos, .cmd_pos, .step_count,
		.phase_current_ff, .equalize_on_ff, .decel_stop_ff, .halt_now_ff, .coast_off_ff, .ignore_target_ff,
		.actual_pos_ff, .status_word_ff);
	assign halt = decel_stop_ff | halt_now_ff | coast_off_ff;
	motion_model peer_u (.clk, .rst_n, .go, .halt, .lag, .motor_running, .run_start, .steps_done, .cmd_pos,
		.step_count, .enc_pos);
	always #25 clk = ~clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] pick(input int unsigned s);
		case (s)
			0: return {16'h0, reg_rdata_ff};
			1: return {16'h0, phase_current_ff};
			2: return {16'h0, status_word_ff};
			3: return {31'h0, equalize_on_ff};
			4: return actual_pos_ff;
			6: return {31'h0, coast_off_ff};
			default: return {31'h0, status_word_ff[BIT_LAG]};
		endcase
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		if (err_total == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
	endtask
	// expected value is queued; the watcher compares right after the next edge
	task automatic note(input int unsigned s, input logic [31:0] v);
		@(posedge clk);
		q.push_back('{s, v});
		look <= 1'b1;
		@(posedge clk);
		look <= 1'b0;
	endtask
	task automatic wr(input addr_t a, input word_t d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input addr_t a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		note(0, e);
	endtask
	task automatic run;
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask
	task automatic wait_stop;
		for (int i = 0; i < 200 && motor_running; i++) @(posedge clk);
		settle(3);
	endtask
	// watcher: oldest note against the output it names
	always @(negedge clk) begin
		if (look) begin
			chk(pick(q[0].sel), q[0].val);
			q.delete(0);
		end
	end
	// watchdog sized well above the whole sequence
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		give_verdict();
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++) rd(ADDR_RATIO + 16'(i), rst_v[i]);
		note(1, 32'h2BC);
		rd(ADDR_CPR, 32'h190);
		rd(ADDR_RED_PCT, 32'h32);
		wr(16'h0440, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			r = {25'h0, seed[6:0]} % 32'h79;
			wr(ADDR_RATIO, r[15:0]);
			rd(ADDR_RATIO, r);
			note(1, r * 32'hA);
		end
		wr(ADDR_RATIO, 16'h0079);
		rd(ADDR_RATIO, r);
		// settings while moving, then standstill reduction
		wr(ADDR_RATIO, 16'h0064);
		run();
		wr(ADDR_EQ, 16'h0001);
		wait_stop();
		note(1, 32'h3E8);
		rd(ADDR_EQ, 32'h0);
		settle(18);
		note(1, 32'h1F4);
		wr(ADDR_EQ, 16'h0001);
		note(3, 32'h1);
		wr(ADDR_SYNC_EN, 16'h0001);
		note(3, 32'h0);
		wr(ADDR_SYNC_EN, 16'h0000);
		wr(ADDR_REDUCE, 16'h0000);
		run();
		wait_stop();
		settle(24);
		note(1, 32'h3E8);
		// every window code, at and one past its limit, stop reaction
		for (int c = 0; c < 6; c++) begin
			wr(ADDR_WIN, 16'(c));
			run_has_ramp <= c[0];
			lag <= 32'(WIN_MULT[c]);
			run();
			settle(4);
			note(5, 32'h0);
			lag <= 32'(WIN_MULT[c]) + 32'h1;
			settle(4);
			note(5, 32'h1);
			lag <= 32'h0;
			wait_stop();
			note(2, 32'h3637);
		end
		current_on <= 1'b0;
		settle(3);
		note(5, 32'h0);
		current_on <= 1'b1;
		// coast reaction into fault and out again
		wr(ADDR_REACT, 16'h0002);
		run();
		lag <= 32'h0B;
		settle(3);
		note(2, 32'(SW_COAST));
		lag <= 32'h0;
		wait_stop();
		note(2, 32'(SW_FAULT));
		control_word <= CW_FAULT_RST;
		settle(4);
		control_word <= 16'h0000;
		note(6, 32'h0);
		// no-encoder code only below operation enabled
		wr(ADDR_REACT, 16'h0011);
		rd(ADDR_REACT, 32'h2);
		op_enabled <= 1'b0;
		wr(ADDR_REACT, 16'h0011);
		op_enabled <= 1'b1;
		rd(ADDR_REACT, 32'h11);
		lag <= 32'h40;
		run();
		settle(6);
		note(5, 32'h0);
		wait_stop();
		note(4, cmd_pos);
		lag <= 32'h0;
		// keep-running reaction: flag held, clear command rules
		wr(ADDR_REACT, 16'h0001);
		wr(ADDR_WIN, 16'h0000);
		run();
		lag <= 32'h2;
		settle(3);
		lag <= 32'h0;
		wait_stop();
		note(2, 32'h3637);
		run();
		settle(4);
		note(5, 32'h1);
		wait_stop();
		op_enabled <= 1'b0;
		wr(ADDR_CLR, 16'h0001);
		note(5, 32'h1);
		wr(ADDR_CLR, 16'h0000);
		op_enabled <= 1'b1;
		wr(ADDR_CLR, 16'h0001);
		note(5, 32'h0);
		wr(ADDR_CLR, 16'h0000);
		// resync window replaces the code and clears on recovery
		wr(ADDR_SYNC_WL, 16'h0003);
		wr(ADDR_SYNC_EN, 16'h0001);
		lag <= 32'h3;
		settle(4);
		note(5, 32'h0);
		lag <= 32'h4;
		settle(4);
		note(5, 32'h1);
		lag <= 32'h0;
		settle(4);
		note(5, 32'h0);
		wr(ADDR_SYNC_EN, 16'h0000);
		// load step counter; left last since it leaves an encoder offset
		lag <= 32'h7;
		settle(4);
		wr(ADDR_CLR, 16'h0002);
		note(4, step_count);
		wr(ADDR_CLR, 16'h0000);
		settle(4);
		give_verdict();
	end
endmodule
bind stepper_current_and_following_error lag_error_chk #(.REDUCE_CYCLES(REDUCE_CYCLES)) chk_u (.clk, .rst_n,
	.reg_addr, .reg_wr, .reg_wdata, .op_enabled, .current_on, .run_has_ramp, .control_word, .enc_pos, .cmd_pos,
	.decel_stop_ff, .halt_now_ff, .coast_off_ff, .ignore_target_ff, .actual_pos_ff, .status_word_ff);
`default_nettype wire
